//--- hdl/modbus_exception_responder.sv
// Query validation and exception reply frame builder for the serial slave
// =====================================================================
// What this block does
// - A query that cannot be carried out gets an exception reply in place of the normal answer.
// - The reply is station byte, function byte, exception code byte and a CRC sent low byte first.
// - The reply function byte is the query function code with its top bit set.
// - Function codes other than 01h, 03h, 05h, 08h, 0Fh and 10h give exception code 01h.
// - Register read or write at an unmapped register address gives exception code 02h.
// - A register write to a read-only register address gives exception code 02h.
// - A coil query at an unmapped coil address gives exception code 02h.
// - A coil write to a read-only coil address gives exception code 02h.
// - A register count of zero, odd or above the maximum gives exception code 03h.
// - A register write byte count that disagrees with the register count gives exception code 03h.
// - A register write value outside its permitted range gives exception code 03h.
// - A coil read or multiple coil write count of zero or above the maximum gives exception code 03h.
// - A multiple coil write byte count that disagrees with the coil count gives exception code 03h.
// - A single coil write whose value is neither ON nor OFF gives exception code 03h.
module modbus_exception_responder #(
  parameter int MAX_REGS = 16,
  parameter int MAX_COILS = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic query_valid,
  output logic query_ready,
  input wire exc_pkg::query_s query,
  output logic result_valid,
  output logic result_fault,
  output logic [7:0] result_code,
  output logic reply_valid,
  input wire logic reply_ready,
  output exc_pkg::reply_byte_s reply
);
  import exc_pkg::*;

  // =====================================================================
  // Types and state
  typedef enum logic [1:0] {IDLE, SEND, DRAIN} phase_e;

  typedef struct packed {
    phase_e phase;
    logic [7:0] station;
    logic [7:0] fc;
    logic [7:0] code;
    logic [15:0] crc;
    logic [2:0] idx;
    logic res_valid;
    logic res_fault;
    logic [7:0] res_code;
  } ctl_state_s;

  localparam logic [2:0] LAST_IDX = 3'(REPLY_BYTES - 1);
  localparam logic [15:0] MAX_REGS_W = 16'(MAX_REGS);
  localparam logic [15:0] MAX_COILS_W = 16'(MAX_COILS);

  ctl_state_s st;
  ctl_state_s next_st;
  logic [7:0] exc_code;
  logic is_reg_fc;
  logic is_coil_fc;
  logic [7:0] coil_bytes;
  logic [15:0] crc_next;
  reply_byte_s cur_byte;
  logic buf_in_ready;
  logic buf_out_valid;
  reply_byte_s buf_out;

  // =====================================================================
  // CRC-16 byte update, reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] crc_in, input logic [7:0] d);
    logic [15:0] c;
    c = crc_in ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      if (c[0])
        c = (c >> 1) ^ CRC_POLY;
      else
        c = c >> 1;
    end
    return c;
  endfunction

  // =====================================================================
  // Query checks
  // Coil byte count expected for a multiple coil write
  always_comb
  begin
    coil_bytes = 8'((query.count + 16'd7) >> 3);
  end

  // Ordered checks, first failure wins
  always_comb
  begin
    is_reg_fc = (query.fc == FC_READ_REGS) || (query.fc == FC_WRITE_REGS);
    is_coil_fc = (query.fc == FC_READ_COILS) || (query.fc == FC_WRITE_COIL) || (query.fc == FC_WRITE_COILS);
    exc_code = EXC_NONE;
    if (!(is_reg_fc || is_coil_fc || query.fc == FC_DIAG))
      exc_code = EXC_BAD_FC;
    else if (is_reg_fc && !query.addr_known)
      exc_code = EXC_BAD_ADDR;
    else if (query.fc == FC_WRITE_REGS && query.addr_read_only)
      exc_code = EXC_BAD_ADDR;
    else if (is_coil_fc && !query.addr_known)
      exc_code = EXC_BAD_ADDR;
    else if ((query.fc == FC_WRITE_COIL || query.fc == FC_WRITE_COILS) && query.addr_read_only)
      exc_code = EXC_BAD_ADDR;
    else if (is_reg_fc && (query.count == 16'h0000 || query.count[0] || query.count > MAX_REGS_W))
      exc_code = EXC_BAD_DATA;
    else if (query.fc == FC_WRITE_REGS && query.byte_count != 8'({query.count, 1'b0}))
      exc_code = EXC_BAD_DATA;
    else if (query.fc == FC_WRITE_REGS && !query.value_in_range)
      exc_code = EXC_BAD_DATA;
    else if (query.fc == FC_WRITE_COIL && query.value != COIL_ON && query.value != COIL_OFF)
      exc_code = EXC_BAD_DATA;
    else if ((query.fc == FC_READ_COILS || query.fc == FC_WRITE_COILS)
             && (query.count == 16'h0000 || query.count > MAX_COILS_W))
      exc_code = EXC_BAD_DATA;
    else if (query.fc == FC_WRITE_COILS && query.byte_count != coil_bytes)
      exc_code = EXC_BAD_DATA;
  end

  // =====================================================================
  // Reply byte selection
  always_comb
  begin
    cur_byte.last = (st.idx == LAST_IDX);
    case (st.idx)
      3'd0: cur_byte.data = st.station;
      3'd1: cur_byte.data = st.fc | FC_ERR_BIT;
      3'd2: cur_byte.data = st.code;
      3'd3: cur_byte.data = st.crc[7:0];
      3'd4: cur_byte.data = st.crc[15:8];
      default: cur_byte.data = 8'h00;
    endcase
    crc_next = crc_step(st.crc, cur_byte.data);
  end

  // =====================================================================
  // Control sequence
  always_comb
  begin
    next_st = st;
    next_st.res_valid = 1'b0;
    case (st.phase)
      IDLE:
      begin
        if (query_valid)
        begin
          next_st.res_valid = 1'b1;
          next_st.res_fault = (exc_code != EXC_NONE);
          next_st.res_code = exc_code;
          if (exc_code != EXC_NONE)
          begin
            next_st.phase = SEND;
            next_st.station = query.station;
            next_st.fc = query.fc;
            next_st.code = exc_code;
            next_st.crc = CRC_INIT;
            next_st.idx = 3'd0;
          end
        end
      end
      SEND:
      begin
        if (buf_in_ready)
        begin
          // CRC bytes themselves are not folded in
          if (st.idx < 3'd3)
            next_st.crc = crc_next;
          if (cur_byte.last)
            next_st.phase = DRAIN;
          else
            next_st.idx = st.idx + 3'd1;
        end
      end
      DRAIN:
      begin
        if (!buf_out_valid)
          next_st.phase = IDLE;
      end
      default: next_st.phase = IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.phase <= IDLE;
    end
    else
      st <= next_st;
  end

  // =====================================================================
  // Reply buffer and outputs
  reply_buffer u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(st.phase == SEND),
    .in_ready(buf_in_ready),
    .in_data(cur_byte),
    .out_valid(buf_out_valid),
    .out_ready(reply_ready),
    .out_data(buf_out)
  );

  assign query_ready = (st.phase == IDLE);
  assign result_valid = st.res_valid;
  assign result_fault = st.res_fault;
  assign result_code = st.res_code;
  assign reply_valid = buf_out_valid;
  assign reply = buf_out;
endmodule

//--- hdl/exc_pkg.sv
// Package of constants and carriers for the query checker and exception reply builder
package exc_pkg;
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_REGS = 8'h03;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITE_COILS = 8'h0f;
  localparam logic [7:0] FC_WRITE_REGS = 8'h10;
  localparam logic [7:0] EXC_BAD_FC = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] EXC_BAD_DATA = 8'h03;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] FC_ERR_BIT = 8'h80;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam int REPLY_BYTES = 5;

  // Decoded query fields offered by the frame parser
  typedef struct packed {
    logic [7:0] station;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] count;
    logic [7:0] byte_count;
    logic [15:0] value;
    logic addr_known;
    logic addr_read_only;
    logic value_in_range;
  } query_s;

  // One byte of the reply stream
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } reply_byte_s;
endpackage

//--- hdl/reply_buffer.sv
// Two-entry buffer carrying reply bytes to the serial transmitter
module reply_buffer
  import exc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire exc_pkg::reply_byte_s in_data,
  output logic out_valid,
  input wire logic out_ready,
  output exc_pkg::reply_byte_s out_data
);
  import exc_pkg::*;

  typedef struct packed {
    reply_byte_s [1:0] slot;
    logic [1:0] fill;
  } buf_state_s;

  buf_state_s st;
  buf_state_s next_st;
  logic push;
  logic pop;

  // Push and pop with the head always in slot zero
  always_comb
  begin
    next_st = st;
    push = in_valid && (st.fill != 2'd2);
    pop = out_ready && (st.fill != 2'd0);
    if (pop)
    begin
      next_st.slot[0] = st.slot[1];
      next_st.fill = st.fill - 2'd1;
    end
    if (push)
    begin
      next_st.slot[next_st.fill[0]] = in_data;
      next_st.fill = next_st.fill + 2'd1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign in_ready = (st.fill != 2'd2);
  assign out_valid = (st.fill != 2'd0);
  assign out_data = st.slot[0];
endmodule

//--- test/modbus_exception_responder_assertions.sv
// Port checker of the exception responder
module modbus_exception_responder_assertions
  import exc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic query_valid,
  input wire logic query_ready,
  input wire exc_pkg::query_s query,
  input wire logic result_valid,
  input wire logic result_fault,
  input wire logic [7:0] result_code,
  input wire logic reply_valid,
  input wire logic reply_ready,
  input wire exc_pkg::reply_byte_s reply
);
  logic tk;
  logic sup;
  // Take strobe and supported code decode
  assign tk = query_valid && query_ready;
  assign sup = query.fc inside {8'h01, 8'h03, 8'h05, 8'h08, 8'h0f, 8'h10};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Assertions
  AST_RES: assert property (tk |=> result_valid) else $error("missing result pulse");
  AST_NORES: assert property (!tk |=> !result_valid) else $error("stray result pulse");
  AST_REPLY: assert property (result_valid && result_fault |-> !query_ready ##1 reply_valid) else $error("no reply");
  AST_QUIET: assert property (result_valid && !result_fault |-> !reply_valid) else $error("stray reply");
  AST_BUSY: assert property (reply_valid |-> !query_ready) else $error("ready while sending");
  AST_FC: assert property (tk && !sup |=> result_code == EXC_BAD_FC) else $error("bad fc code");
  AST_ADDR: assert property (tk && sup && query.fc != 8'h08 && !query.addr_known |=> result_code == 8'h02)
    else $error("bad addr code");
  AST_KIND: assert property (result_valid |-> result_fault == (result_code != 8'h00)) else $error("bad fault");
  AST_HOLD: assert property (reply_valid && !reply_ready |=> reply_valid && $stable(reply)) else $error("lost byte");
  AST_LAST: assert property (reply_valid && reply_ready && reply.last |=> !reply_valid) else $error("over length");
  C_FC: cover property (tk && !sup);
  C_STALL: cover property (reply_valid && !reply_ready);
  C_OK: cover property (result_valid && !result_fault);
endmodule

bind modbus_exception_responder modbus_exception_responder_assertions chk (.*);

//--- test/reply_sink.sv
// Receiver model that takes reply bytes, stalling on request
module reply_sink
  import exc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic reply_valid,
  input wire exc_pkg::reply_byte_s reply,
  output logic reply_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  logic [8:0] got [$];
  // When stalling, accept one cycle in four
  assign reply_ready = !stall || ph == 2'h3;
  // Collect accepted bytes in arrival order
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ph <= 2'h0;
    else
    begin
      ph <= ph + 2'h1;
      if (reply_valid && reply_ready)
        got.push_back(reply);
    end
  end
endmodule

//--- test/modbus_exception_responder_test.sv
// Self-checking bench of the exception responder
module modbus_exception_responder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import exc_pkg::*;
  localparam logic [7:0] GOOD [6] = '{8'h01, 8'h03, 8'h05, 8'h08, 8'h0f, 8'h10};
  logic clk = 0, rst_n = 0, query_valid = 0, stall = 0;
  logic query_ready, result_valid, result_fault, reply_valid, reply_ready;
  logic [7:0] result_code;
  query_s query = '0;
  reply_byte_s reply;
  int failures = 0, tests_run = 0, cycles = 0;
  modbus_exception_responder dut (.clk(clk), .rst_n(rst_n), .query_valid(query_valid), .query_ready(query_ready),
    .query(query), .result_valid(result_valid), .result_fault(result_fault), .result_code(result_code),
    .reply_valid(reply_valid), .reply_ready(reply_ready), .reply(reply));
  reply_sink sink (.clk(clk), .rst_n(rst_n), .stall(stall), .reply_valid(reply_valid), .reply(reply),
    .reply_ready(reply_ready));
  // ==========
  // Clock and hang guard
  initial forever #2 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      stop_test();
    end
  end
  // ==========
  // Helpers
  function automatic logic [15:0] crc16(logic [23:0] m);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 2; i >= 0; i--)
    begin
      c ^= {8'h00, m[i*8+:8]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  function automatic query_s mk(logic [7:0] fc);
    query_s q;
    q = {8'h11, fc, 16'h0001, 16'h0002, 8'h04, COIL_ON, 3'b101};
    if (fc inside {8'h01, 8'h05, 8'h0f})
      {q.count, q.byte_count} = {16'h0001, 8'h01};
    return q;
  endfunction
  task automatic cmp(logic [8:0] got, logic [8:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Offer one query, then judge the result and any reply frame
  task automatic chk(query_s q, logic [7:0] code);
    logic [15:0] c;
    logic [8:0] f [5];
    int n;
    for (n = 0; n < 50 && query_ready !== 1'b1; n++)
      @(negedge clk);
    query = q;
    query_valid = 1;
    @(negedge clk);
    query_valid = 0;
    cmp({8'h00, result_valid}, 9'h001);
    cmp({result_fault, result_code}, {code != EXC_NONE, code});
    c = crc16({q.station, q.fc | FC_ERR_BIT, code});
    f = '{{q.station, 1'b0}, {q.fc | FC_ERR_BIT, 1'b0}, {code, 1'b0}, {c[7:0], 1'b0}, {c[15:8], 1'b1}};
    for (n = 0; n < 100 && code != EXC_NONE && sink.got.size() < 5; n++)
      @(negedge clk);
    cmp(9'(sink.got.size()), (code != EXC_NONE) ? 9'd5 : 9'd0);
    for (n = 0; n < sink.got.size() && n < 5; n++)
      cmp(sink.got[n], f[n]);
    sink.got.delete();
    // One idle edge so the next query never re-raises valid in this time step
    @(negedge clk);
  endtask
  task automatic dchk(logic [7:0] fc, logic [15:0] n, logic [7:0] bc, logic [15:0] v, logic inr, logic [7:0] code);
    query_s q;
    q = mk(fc);
    {q.count, q.byte_count, q.value, q.value_in_range} = {n, bc, v, inr};
    chk(q, code);
  endtask
  // ==========
  // Scenarios
  task automatic t_fc();
    logic [7:0] bad [4] = '{8'h00, 8'h02, 8'h7f, 8'h81};
    foreach (GOOD[i])
      chk(mk(GOOD[i]), EXC_NONE);
    foreach (bad[i])
      chk(mk(bad[i]), EXC_BAD_FC);
    $display("function code test done");
  endtask
  task automatic t_addr();
    query_s q;
    stall = 1;
    foreach (GOOD[i])
      if (GOOD[i] != FC_DIAG)
      begin
        q = mk(GOOD[i]);
        q.addr_read_only = 1;
        chk(q, (GOOD[i] inside {8'h01, 8'h03}) ? EXC_NONE : EXC_BAD_ADDR);
        q.addr_known = 0;
        chk(q, EXC_BAD_ADDR);
      end
    stall = 0;
    $display("address test done");
  endtask
  task automatic t_data();
    dchk(8'h03, 0, 0, 0, 1, EXC_BAD_DATA);
    dchk(8'h03, 3, 6, 0, 1, EXC_BAD_DATA);
    dchk(8'h03, 18, 36, 0, 1, EXC_BAD_DATA);
    dchk(8'h03, 16, 32, 0, 1, EXC_NONE);
    dchk(8'h10, 2, 6, 0, 1, EXC_BAD_DATA);
    dchk(8'h10, 2, 4, 0, 0, EXC_BAD_DATA);
    dchk(8'h01, 0, 0, 0, 1, EXC_BAD_DATA);
    dchk(8'h01, 17, 3, 0, 1, EXC_BAD_DATA);
    dchk(8'h01, 16, 2, 0, 1, EXC_NONE);
    dchk(8'h0f, 9, 1, 0, 1, EXC_BAD_DATA);
    dchk(8'h0f, 9, 2, 0, 1, EXC_NONE);
    dchk(8'h05, 1, 1, 16'h1234, 1, EXC_BAD_DATA);
    dchk(8'h05, 1, 1, COIL_OFF, 1, EXC_NONE);
    $display("data test done");
  endtask
  task automatic t_order();
    query_s q;
    q = mk(8'h04);
    {q.addr_known, q.count} = 17'h0;
    chk(q, EXC_BAD_FC);
    q.fc = FC_READ_REGS;
    chk(q, EXC_BAD_ADDR);
    q.fc = FC_DIAG;
    chk(q, EXC_NONE);
    $display("order test done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Reset, then run every scenario
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    t_fc();
    t_addr();
    t_data();
    t_order();
    stop_test();
  end
endmodule
